// ===== fsec_eng_model.sv
`timescale 1ns/1ps
// auto program/erase engine: done after a chosen latency
module fsec_eng_model
	import fsec_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic       start_i,
	input  wire logic [3:0] lat_i,
	input  wire logic       fail_i,
	output fsec_eng_t       eng_o
);
	logic [3:0] cnt_q;
	logic       run_q;
	// done is a single pulse, so a stuck done shows up as a second op end
	always_ff @(posedge ref_clk_i) begin
		eng_o <= '0;
		if (reset_i) begin
			run_q <= 1'b0;
		end else if (start_i) begin
			run_q <= 1'b1;
			cnt_q <= lat_i;
		end else if (run_q && cnt_q == 4'h0) begin
			run_q <= 1'b0;
			eng_o <= {1'b1, fail_i};
		end else if (run_q) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule // fsec_eng_model

// ===== fsec_pkg.sv
package fsec_pkg;

	// ==========================================================
	// command codes (first and second bus cycle)
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM      = 8'h40;
	localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;

	// ==========================================================
	// status word field positions
	localparam int SR_READY_POS   = 7;
	localparam int SR_ERASE_POS   = 5;
	localparam int SR_PROGRAM_POS = 4;

	// ==========================================================
	// reset values
	localparam logic RST_READY      = 1'b1;
	localparam logic RST_ERASE_FAIL = 1'b0;
	localparam logic RST_PROG_FAIL  = 1'b0;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ==========================================================
	// bus write from the cpu
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       addr_in_flash;
		logic       addr_block;
		logic       addr_match;
	} fsec_wr_t;

	// ==========================================================
	// result from the auto program/erase engine
	typedef struct packed {
		logic done;
		logic fail;
	} fsec_eng_t;

	// ==========================================================
	// command decoder states
	typedef enum logic [2:0] {
		ST_READ_ARRAY,
		ST_READ_STATUS,
		ST_PROG_WAIT,
		ST_ERASE_WAIT,
		ST_BUSY_PROG,
		ST_BUSY_ERASE
	} fsec_state_t;

endpackage

// ===== fsec_top.sv
`timescale 1ns/1ps

module fsec_top
	import fsec_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire fsec_wr_t   wr_i,
	input  wire logic       rd_i,
	input  wire logic       rewrite_enable_bit_i,
	input  wire logic       block_zero_lock_i,
	input  wire logic       block_one_lock_i,
	input  wire fsec_eng_t  eng_i,
	output logic [7:0]      rdata_o,
	output logic            status_mode_o,
	output logic            start_program_o,
	output logic            start_erase_o,
	output logic            ctl0_ready_mirror_o,
	output logic            ctl0_program_fail_mirror_o,
	output logic            ctl0_erase_fail_mirror_o
);

	// ==========================================================
	// state
	fsec_state_t state_q;
	fsec_state_t state_d;
	logic        seq_ready_flag_q;
	logic        erase_fail_flag_q;
	logic        program_fail_flag_q;
	logic        status_mode_q;
	logic [7:0]  rdata_q;
	logic        start_prog_q;
	logic        start_erase_q;

	// set/clear events from the decoder
	logic        seq_err;
	logic        go_prog;
	logic        go_erase;
	logic        clr_stat;

	// ==========================================================
	// helpers
	// a block may be rewritten only with global enable and no lock
	function automatic logic fsec_block_ok(input logic blk, input logic en,
		input logic lk0, input logic lk1);
		fsec_block_ok = en && (blk ? !lk1 : !lk0);
	endfunction

	function automatic logic fsec_target_ok(input fsec_wr_t w, input logic en,
		input logic lk0, input logic lk1);
		fsec_target_ok = w.addr_in_flash && fsec_block_ok(w.addr_block, en, lk0, lk1);
	endfunction

	logic err_any;
	assign err_any = erase_fail_flag_q || program_fail_flag_q;

	// ==========================================================
	// command decoder
	always_comb begin
		state_d  = state_q;
		seq_err  = 1'b0;
		go_prog  = 1'b0;
		go_erase = 1'b0;
		clr_stat = 1'b0;
		case (state_q)
			ST_BUSY_PROG: begin
				if (eng_i.done) begin
					state_d = ST_READ_STATUS;
				end
			end
			ST_BUSY_ERASE: begin
				if (eng_i.done) begin
					state_d = ST_READ_STATUS;
				end
			end
			ST_PROG_WAIT: begin
				if (wr_i.valid) begin
					if (wr_i.data == CMD_READ_ARRAY) begin
						state_d = ST_READ_ARRAY;
					end else if (err_any) begin
						state_d = ST_READ_STATUS;
					end else if (!wr_i.addr_match ||
						!fsec_target_ok(wr_i, rewrite_enable_bit_i,
						block_zero_lock_i, block_one_lock_i)) begin
						seq_err = 1'b1;
						state_d = ST_READ_STATUS;
					end else begin
						go_prog = 1'b1;
						state_d = ST_BUSY_PROG;
					end
				end
			end
			ST_ERASE_WAIT: begin
				if (wr_i.valid) begin
					if (wr_i.data == CMD_READ_ARRAY) begin
						state_d = ST_READ_ARRAY;
					end else if (wr_i.data != CMD_ERASE_CONFIRM) begin
						seq_err = 1'b1;
						state_d = ST_READ_STATUS;
					end else if (err_any) begin
						state_d = ST_READ_STATUS;
					end else if (!fsec_target_ok(wr_i, rewrite_enable_bit_i,
						block_zero_lock_i, block_one_lock_i)) begin
						seq_err = 1'b1;
						state_d = ST_READ_STATUS;
					end else begin
						go_erase = 1'b1;
						state_d  = ST_BUSY_ERASE;
					end
				end
			end
			default: begin
				// idle modes: read array or read status
				if (wr_i.valid) begin
					if (wr_i.data == CMD_READ_ARRAY) begin
						state_d = ST_READ_ARRAY;
					end else if (wr_i.data == CMD_READ_STATUS) begin
						state_d = ST_READ_STATUS;
					end else if (wr_i.data == CMD_CLEAR_STATUS) begin
						clr_stat = 1'b1;
					end else if (wr_i.data == CMD_PROGRAM) begin
						state_d = ST_PROG_WAIT;
					end else if (wr_i.data == CMD_BLOCK_ERASE) begin
						state_d = ST_ERASE_WAIT;
					end else begin
						seq_err = 1'b1;
						state_d = ST_READ_STATUS;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// decoder register; writes during busy are ignored
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q <= ST_READ_ARRAY;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// status mode flag registered from the next state, so the pin comes
	// straight from a flop yet tracks state_q cycle for cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			status_mode_q <= 1'b0;
		end else begin
			status_mode_q <= (state_d != ST_READ_ARRAY);
		end
	end

	// ==========================================================
	// start pulses to the engine, one cycle each
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			start_prog_q  <= 1'b0;
			start_erase_q <= 1'b0;
		end else begin
			start_prog_q  <= go_prog;
			start_erase_q <= go_erase;
		end
	end

	// ==========================================================
	// sequencer ready: low from accepted start until engine done
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			seq_ready_flag_q <= RST_READY;
		end else if (go_prog || go_erase) begin
			seq_ready_flag_q <= 1'b0;
		end else if ((state_q == ST_BUSY_PROG || state_q == ST_BUSY_ERASE)
			&& eng_i.done) begin
			seq_ready_flag_q <= 1'b1;
		end
	end

	// ==========================================================
	// error flags; any set in the same cycle wins over clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			erase_fail_flag_q <= RST_ERASE_FAIL;
		end else if (seq_err ||
			(state_q == ST_BUSY_ERASE && eng_i.done && eng_i.fail)) begin
			erase_fail_flag_q <= 1'b1;
		end else if (clr_stat) begin
			erase_fail_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			program_fail_flag_q <= RST_PROG_FAIL;
		end else if (seq_err ||
			(state_q == ST_BUSY_PROG && eng_i.done && eng_i.fail)) begin
			program_fail_flag_q <= 1'b1;
		end else if (clr_stat) begin
			program_fail_flag_q <= 1'b0;
		end
	end

	// ==========================================================
	// read data: registered one cycle after rd_i; status word in
	// status modes, zero in read array (array data comes elsewhere)
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_q <= RST_RDATA;
		end else if (rd_i) begin
			rdata_q <= RST_RDATA; // reserved bits zero
			if (state_q != ST_READ_ARRAY) begin
				rdata_q[SR_READY_POS]   <= seq_ready_flag_q;
				rdata_q[SR_ERASE_POS]   <= erase_fail_flag_q;
				rdata_q[SR_PROGRAM_POS] <= program_fail_flag_q;
			end
		end
	end

	// ==========================================================
	// outputs; mirrors are the flags themselves
	assign rdata_o                    = rdata_q;
	assign status_mode_o              = status_mode_q;
	assign start_program_o            = start_prog_q;
	assign start_erase_o              = start_erase_q;
	assign ctl0_ready_mirror_o        = seq_ready_flag_q;
	assign ctl0_program_fail_mirror_o = program_fail_flag_q;
	assign ctl0_erase_fail_mirror_o   = erase_fail_flag_q;

endmodule // fsec_top

// ===== fsec_top_properties.sv
`timescale 1ns/1ps
// ==========
// status flag checker
module fsec_chk
	import fsec_pkg::*;
(
	input wire logic      ref_clk_i,
	input wire logic      reset_i,
	input wire fsec_wr_t  wr_i,
	input wire logic      rd_i,
	input wire fsec_eng_t eng_i,
	input wire logic [7:0] rdata_o,
	input wire logic      status_mode_o,
	input wire logic      start_program_o,
	input wire logic      start_erase_o,
	input wire logic      ctl0_ready_mirror_o,
	input wire logic      ctl0_program_fail_mirror_o,
	input wire logic      ctl0_erase_fail_mirror_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic er_q;
	// remembers which operation the engine runs
	always_ff @(posedge ref_clk_i) begin
		if (start_program_o | start_erase_o) er_q <= start_erase_o;
	end
	sequence erase_open; wr_i.valid && wr_i.data == 8'h20 && ctl0_ready_mirror_o; endsequence
	sequence bad_cfm; wr_i.valid && wr_i.data != 8'hD0 && wr_i.data != 8'hFF; endsequence
	chk_rd_word: assert property (rd_i && status_mode_o |=> rdata_o == {
		$past(ctl0_ready_mirror_o), 1'b0, $past(ctl0_erase_fail_mirror_o),
		$past(ctl0_program_fail_mirror_o), 4'h0}) else $error("status word wrong");
	chk_err_blocks: assert property ($past(ctl0_program_fail_mirror_o | ctl0_erase_fail_mirror_o)
		|-> !(start_program_o | start_erase_o)) else $error("start while error latched");
	chk_clear_flags: assert property (wr_i.valid && wr_i.data == 8'h50 && ctl0_ready_mirror_o
		|=> !ctl0_program_fail_mirror_o && !ctl0_erase_fail_mirror_o) else $error("clear failed");
	chk_busy_start: assert property (start_program_o || start_erase_o |-> !ctl0_ready_mirror_o)
		else $error("ready high at start");
	chk_ready_back: assert property (!ctl0_ready_mirror_o && eng_i.done |=> ctl0_ready_mirror_o)
		else $error("ready not restored");
	chk_prog_fail: assert property (!ctl0_ready_mirror_o && eng_i.done && eng_i.fail && !er_q
		|=> ctl0_program_fail_mirror_o && !ctl0_erase_fail_mirror_o) else $error("program fail");
	chk_erase_fail: assert property (!ctl0_ready_mirror_o && eng_i.done && eng_i.fail && er_q
		|=> !ctl0_program_fail_mirror_o && ctl0_erase_fail_mirror_o) else $error("erase fail");
	chk_bad_confirm: assert property (erase_open ##1 bad_cfm
		|=> ctl0_program_fail_mirror_o && ctl0_erase_fail_mirror_o) else $error("no seq error");
	chk_ff_cancel: assert property (erase_open ##1 (wr_i.valid && wr_i.data == 8'hFF)
		|=> !status_mode_o && !start_erase_o) else $error("cancel failed");
endmodule // fsec_chk
bind fsec_top fsec_chk fsec_chk_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .wr_i(wr_i),
	.rd_i(rd_i), .eng_i(eng_i), .rdata_o(rdata_o), .status_mode_o(status_mode_o),
	.start_program_o(start_program_o), .start_erase_o(start_erase_o),
	.ctl0_ready_mirror_o(ctl0_ready_mirror_o),
	.ctl0_program_fail_mirror_o(ctl0_program_fail_mirror_o),
	.ctl0_erase_fail_mirror_o(ctl0_erase_fail_mirror_o));

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
	import fsec_pkg::*;
	logic       ref_clk_i = 0, reset_i = 1, rd_i = 0, rd_q = 0, en = 1, lk0 = 0, lk1 = 0, fl = 0;
	fsec_wr_t   wr_i = '0;
	fsec_eng_t  eng;
	logic [7:0] rdata, exp_q[$], exp_v;
	logic       sm, sp, se, rdy, pf, ef;
	logic [31:0] rnd = 32'h4F22;
	int         err_total = 0, cmp_count = 0, cyc = 0, starts = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	fsec_top fsec_top_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
		.rewrite_enable_bit_i(en), .block_zero_lock_i(lk0), .block_one_lock_i(lk1), .eng_i(eng),
		.rdata_o(rdata), .status_mode_o(sm), .start_program_o(sp), .start_erase_o(se),
		.ctl0_ready_mirror_o(rdy), .ctl0_program_fail_mirror_o(pf), .ctl0_erase_fail_mirror_o(ef));
	fsec_eng_model fsec_eng_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .start_i(sp | se),
		.lat_i(rnd[3:0]), .fail_i(fl), .eng_o(eng));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task complete_run;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [7:0] d, input logic f = 1, input logic b = 0);
		wr_i <= {1'b1, d, f, b, 1'b1};
		@(negedge ref_clk_i);
	endtask
	task idle(input int n);
		wr_i <= '0;
		repeat (n) @(negedge ref_clk_i);
	endtask
	// read status and note the expected word for the monitor
	task st(input logic [7:0] e);
		wr(CMD_READ_STATUS);
		wr_i <= '0;
		rd_i <= 1'b1;
		exp_q.push_back(e);
		@(negedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
	endtask
	// cycle count, start count and hang guard
	always @(posedge ref_clk_i) begin
		rd_q <= rd_i;
		cyc <= cyc + 1;
		if (sp | se) starts <= starts + 1;
		if (cyc > 4000) begin
			err_total++;
			complete_run();
		end
	end
	// read data lands one cycle after the read
	always @(negedge ref_clk_i) begin
		if (rd_q) begin
			// pop once: the macro names its expected value twice
			exp_v = exp_q.pop_front();
			`CHK(rdata, exp_v)
		end
	end
	// main sequence
	initial begin
		repeat (3) @(negedge ref_clk_i);
		reset_i <= 1'b0;
		st(8'h80);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			fl <= i[0];
			if (i < 2) begin
				wr(CMD_PROGRAM);
				wr(rnd[15:8] & 8'hFE);
			end else begin
				wr(CMD_BLOCK_ERASE);
				wr(CMD_ERASE_CONFIRM);
			end
			idle(20);
			st(i == 1 ? 8'h90 : (i == 3 ? 8'hA0 : 8'h80));
			if (i[0]) begin
				wr(CMD_PROGRAM);
				wr(8'h3C);
				idle(20);
				st(i == 1 ? 8'h90 : 8'hA0);
				wr(CMD_CLEAR_STATUS);
				st(8'h80);
			end
		end
		`CHK(starts, 4)
		// sequence errors: global enable off, locks, unmapped address, bad confirm, unknown byte
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			en <= (i != 0);
			lk0 <= (i == 1);
			lk1 <= (i == 2);
			if (i < 3) begin
				wr(CMD_PROGRAM, 1'b1, i == 2);
				wr(8'h55, 1'b1, i == 2);
			end else if (i < 5) begin
				wr(CMD_BLOCK_ERASE);
				wr(i == 3 ? CMD_ERASE_CONFIRM : (rnd[7] ? 8'h11 : rnd[7:0]), i == 4);
			end else wr(8'h33);
			idle(2);
			st(8'hB0);
			wr(CMD_CLEAR_STATUS);
		end
		en <= 1'b1;
		lk0 <= 1'b0;
		lk1 <= 1'b0;
		wr(CMD_BLOCK_ERASE);
		wr(CMD_READ_ARRAY);
		idle(1);
		`CHK(sm, 1'b0)
		`CHK(starts, 4)
		st(8'h80);
		complete_run();
	end
endmodule // tb
